// ==== design/asc_setup_regs.sv ====
// Setup control registers of the imaging front end: clamp, timing, mode, power.
// Assumes a serial decoder drives single-cycle byte writes and reads.
`timescale 1ns/1ps
`default_nettype none
module asc_setup_regs #(
  parameter int ADDR_W = asc_pkg::ADDR_W
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic SYNC_TIMING_MODE,
  input wire logic SINGLE_CHANNEL_MODE,
  input wire logic REF_SAMPLE_CLK_PIN,
  output logic [3:0] CLAMP_LEVEL_CODE,
  output logic CLAMP_DAC_OE,
  output logic [1:0] REF_SAMPLE_ADJUST,
  output logic [1:0] MONO_CHANNEL_SEL,
  output logic [1:0] GAIN_OFFSET_SEL,
  output logic REF_PIN_FOR_SAMPLING,
  output logic AUTOCYCLE_ACTIVE,
  output logic RED_CHAN_PWRDN,
  output logic GREEN_CHAN_PWRDN,
  output logic BLUE_CHAN_PWRDN,
  output logic CONVERTER_PWRDN,
  output logic CLAMP_DAC_PWRDN,
  output logic REF_BUFFER_PWRDN,
  output logic COMMON_LEVEL_BUF_PWRDN,
  output logic SOFT_RESET_PULSE,
  output logic CYCLE_RESET_PULSE
);

  generate
    if (ADDR_W < 4) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // Register state
  logic [7:0] clamp_setup_ff;
  logic [7:0] line_setup_ff;
  logic [7:0] pwr_setup_ff;
  logic soft_pulse_ff;
  logic cycle_pulse_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_clamp_setup;
  logic [7:0] nxt_line_setup;
  logic [7:0] nxt_pwr_setup;
  logic nxt_soft_pulse;
  logic nxt_cycle_pulse;
  logic [7:0] nxt_rdata;

  logic wr_soft;
  logic wr_cycle;

  assign wr_soft = REG_WR && hit(REG_ADDR, asc_pkg::OFS_GLOBAL_SOFT_RESET);
  assign wr_cycle = REG_WR && hit(REG_ADDR, asc_pkg::OFS_COLOUR_CYCLE_RESET);

  always_comb begin
    nxt_clamp_setup = clamp_setup_ff;
    nxt_line_setup = line_setup_ff;
    nxt_pwr_setup = pwr_setup_ff;
    // Strobe locations keep no data, only a one-cycle pulse
    nxt_soft_pulse = wr_soft;
    nxt_cycle_pulse = wr_cycle;
    if (wr_soft) begin
      nxt_clamp_setup = asc_pkg::RST_CLAMP_AND_SAMPLE_SETUP;
      nxt_line_setup = asc_pkg::RST_LINE_MODE_SETUP;
      nxt_pwr_setup = asc_pkg::RST_POWER_DOWN_SETUP;
    end else if (REG_WR) begin
      if (hit(REG_ADDR, asc_pkg::OFS_CLAMP_AND_SAMPLE_SETUP)) begin
        nxt_clamp_setup = REG_WDATA & asc_pkg::MASK_CLAMP_AND_SAMPLE_SETUP;
      end
      if (hit(REG_ADDR, asc_pkg::OFS_LINE_MODE_SETUP)) begin
        nxt_line_setup = REG_WDATA & asc_pkg::MASK_LINE_MODE_SETUP;
      end
      if (hit(REG_ADDR, asc_pkg::OFS_POWER_DOWN_SETUP)) begin
        nxt_pwr_setup = REG_WDATA & asc_pkg::MASK_POWER_DOWN_SETUP;
      end
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      nxt_rdata = 8'h00;
      if (hit(REG_ADDR, asc_pkg::OFS_CLAMP_AND_SAMPLE_SETUP)) begin
        nxt_rdata = clamp_setup_ff;
      end
      if (hit(REG_ADDR, asc_pkg::OFS_LINE_MODE_SETUP)) begin
        nxt_rdata = line_setup_ff;
      end
      if (hit(REG_ADDR, asc_pkg::OFS_POWER_DOWN_SETUP)) begin
        nxt_rdata = pwr_setup_ff;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clamp_setup_ff <= asc_pkg::RST_CLAMP_AND_SAMPLE_SETUP;
      line_setup_ff <= asc_pkg::RST_LINE_MODE_SETUP;
      pwr_setup_ff <= asc_pkg::RST_POWER_DOWN_SETUP;
      soft_pulse_ff <= 1'b0;
      cycle_pulse_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      clamp_setup_ff <= nxt_clamp_setup;
      line_setup_ff <= nxt_line_setup;
      pwr_setup_ff <= nxt_pwr_setup;
      soft_pulse_ff <= nxt_soft_pulse;
      cycle_pulse_ff <= nxt_cycle_pulse;
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign SOFT_RESET_PULSE = soft_pulse_ff;
  assign CYCLE_RESET_PULSE = cycle_pulse_ff;

  // Field views
  logic line_en;
  logic colour_autocycle_en_en;
  logic colour_autocycle_en_active;
  logic [1:0] cycle_colour;

  assign line_en = line_setup_ff[asc_pkg::LINE_SEQUENTIAL_EN_BIT];
  assign colour_autocycle_en_en = line_setup_ff[asc_pkg::COLOUR_AUTOCYCLE_EN_BIT];
  assign colour_autocycle_en_active = line_en && colour_autocycle_en_en;

  // Soft reset also restarts the colour sequence
  asc_colour_cycler u_cycler (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .clear(cycle_pulse_ff || soft_pulse_ff),
    .advance_en(colour_autocycle_en_active),
    .ref_pin(REF_SAMPLE_CLK_PIN),
    .colour(cycle_colour)
  );

  // Output stage, one register behind the fields
  logic [3:0] clamp_code_ff;
  logic [1:0] ref_adj_ff;
  logic [1:0] mono_sel_ff;
  logic [1:0] gain_sel_ff;
  logic ref_pin_samp_ff;
  logic colour_autocycle_en_out_ff;
  logic [6:0] pwr_out_ff;
  logic [3:0] nxt_clamp_code;
  logic [1:0] nxt_ref_adj;
  logic [1:0] nxt_mono_sel;
  logic [1:0] nxt_gain_sel;
  logic nxt_ref_pin_samp;
  logic nxt_colour_autocycle_en_out;
  logic [6:0] nxt_pwr_out;

  always_comb begin
    nxt_clamp_code = clamp_setup_ff[asc_pkg::CLAMP_LEVEL_CODE_LSB +: 4];
    // Default position whenever sync-timing mode is off
    nxt_ref_adj = SYNC_TIMING_MODE ? clamp_setup_ff[asc_pkg::REF_SAMPLE_ADJUST_LSB +: 2]
                                   : asc_pkg::REF_ADJUST_DEFAULT;
    nxt_mono_sel = SINGLE_CHANNEL_MODE ? clamp_setup_ff[asc_pkg::MONO_CHANNEL_SEL_LSB +: 2]
                                       : asc_pkg::COLOUR_RED;
    if (colour_autocycle_en_active) begin
      nxt_gain_sel = cycle_colour;
    end else if (line_en) begin
      nxt_gain_sel = line_setup_ff[asc_pkg::GAIN_OFFSET_MUX_SEL_LSB +: 2];
    end else begin
      nxt_gain_sel = asc_pkg::COLOUR_RED;
    end
    // In auto-cycle the pin only steps colours; clamp must use the control bit
    nxt_ref_pin_samp = !colour_autocycle_en_active;
    nxt_colour_autocycle_en_out = colour_autocycle_en_active;
    nxt_pwr_out = pwr_setup_ff[6:0];
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clamp_code_ff <= asc_pkg::CLAMP_LEVEL_RST;
      ref_adj_ff <= asc_pkg::REF_ADJUST_DEFAULT;
      mono_sel_ff <= asc_pkg::COLOUR_RED;
      gain_sel_ff <= asc_pkg::COLOUR_RED;
      ref_pin_samp_ff <= 1'b1;
      colour_autocycle_en_out_ff <= 1'b0;
      pwr_out_ff <= 7'h00;
    end else begin
      clamp_code_ff <= nxt_clamp_code;
      ref_adj_ff <= nxt_ref_adj;
      mono_sel_ff <= nxt_mono_sel;
      gain_sel_ff <= nxt_gain_sel;
      ref_pin_samp_ff <= nxt_ref_pin_samp;
      colour_autocycle_en_out_ff <= nxt_colour_autocycle_en_out;
      pwr_out_ff <= nxt_pwr_out;
    end
  end

  assign CLAMP_LEVEL_CODE = clamp_code_ff;
  assign REF_SAMPLE_ADJUST = ref_adj_ff;
  assign MONO_CHANNEL_SEL = mono_sel_ff;
  assign GAIN_OFFSET_SEL = gain_sel_ff;
  assign REF_PIN_FOR_SAMPLING = ref_pin_samp_ff;
  assign AUTOCYCLE_ACTIVE = colour_autocycle_en_out_ff;
  assign RED_CHAN_PWRDN = pwr_out_ff[asc_pkg::RED_CHAN_PWRDN_BIT];
  assign GREEN_CHAN_PWRDN = pwr_out_ff[asc_pkg::GREEN_CHAN_PWRDN_BIT];
  assign BLUE_CHAN_PWRDN = pwr_out_ff[asc_pkg::BLUE_CHAN_PWRDN_BIT];
  assign CONVERTER_PWRDN = pwr_out_ff[asc_pkg::CONVERTER_PWRDN_BIT];
  assign CLAMP_DAC_PWRDN = pwr_out_ff[asc_pkg::CLAMP_DAC_PWRDN_BIT];
  assign REF_BUFFER_PWRDN = pwr_out_ff[asc_pkg::REF_BUFFER_PWRDN_BIT];
  assign COMMON_LEVEL_BUF_PWRDN = pwr_out_ff[asc_pkg::COMMON_LEVEL_BUF_PWRDN_BIT];
  // Floating the DAC lets an external source drive the bias pin
  assign CLAMP_DAC_OE = !pwr_out_ff[asc_pkg::CLAMP_DAC_PWRDN_BIT];

  // Checks
  sequence seq_soft_write;
    REG_WR && hit(REG_ADDR, asc_pkg::OFS_GLOBAL_SOFT_RESET);
  endsequence

  sequence seq_clamp_write;
    REG_WR && hit(REG_ADDR, asc_pkg::OFS_CLAMP_AND_SAMPLE_SETUP);
  endsequence

  AST_SOFT_PULSE_ONE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    seq_soft_write ##1 !wr_soft |-> SOFT_RESET_PULSE ##1 !SOFT_RESET_PULSE)
    else $error("soft reset pulse not one cycle");

  AST_SOFT_RESTORES: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    seq_soft_write |=> (clamp_setup_ff == asc_pkg::RST_CLAMP_AND_SAMPLE_SETUP) &&
      (line_setup_ff == asc_pkg::RST_LINE_MODE_SETUP) && (pwr_setup_ff == asc_pkg::RST_POWER_DOWN_SETUP)
      ##1 CLAMP_LEVEL_CODE == asc_pkg::CLAMP_LEVEL_RST)
    else $error("soft reset did not restore setup");

  // Counter is red one edge after the pulse, the applied select one edge later
  AST_CYCLE_PULSE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr_cycle |=> CYCLE_RESET_PULSE ##2 (GAIN_OFFSET_SEL == asc_pkg::COLOUR_RED || !AUTOCYCLE_ACTIVE))
    else $error("cycle reset did not select red");

  AST_CLAMP_WRITE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    seq_clamp_write ##1 !wr_soft |=> CLAMP_LEVEL_CODE == $past(REG_WDATA[3:0], 2))
    else $error("clamp code not applied");

  AST_REF_APPLIED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    SYNC_TIMING_MODE |=> REF_SAMPLE_ADJUST == $past(clamp_setup_ff[asc_pkg::REF_SAMPLE_ADJUST_LSB +: 2]))
    else $error("reference adjust not applied in sync timing mode");

  AST_MONO_APPLIED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    SINGLE_CHANNEL_MODE |=> MONO_CHANNEL_SEL == $past(clamp_setup_ff[asc_pkg::MONO_CHANNEL_SEL_LSB +: 2]))
    else $error("mono select not applied in single channel mode");

  AST_PWR_APPLIED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_WR && hit(REG_ADDR, asc_pkg::OFS_POWER_DOWN_SETUP)) |=> ##1
      {COMMON_LEVEL_BUF_PWRDN, REF_BUFFER_PWRDN, CLAMP_DAC_PWRDN, CONVERTER_PWRDN, BLUE_CHAN_PWRDN,
      GREEN_CHAN_PWRDN, RED_CHAN_PWRDN} == $past(REG_WDATA[6:0], 2))
    else $error("power down bits not applied");

  AST_REF_IGNORED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !SYNC_TIMING_MODE |=> REF_SAMPLE_ADJUST == asc_pkg::REF_ADJUST_DEFAULT)
    else $error("reference adjust used while sync timing off");

  AST_MONO_IGNORED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !SINGLE_CHANNEL_MODE |=> MONO_CHANNEL_SEL == asc_pkg::COLOUR_RED)
    else $error("mono select used outside single channel mode");

  AST_MUX_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (line_en && !colour_autocycle_en_en) |=> GAIN_OFFSET_SEL == $past(line_setup_ff[3:2]))
    else $error("mux select not applied in line mode");

  AST_MUX_IGNORED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !line_en |=> (GAIN_OFFSET_SEL == asc_pkg::COLOUR_RED) && !AUTOCYCLE_ACTIVE && REF_PIN_FOR_SAMPLING)
    else $error("line mode fields acted while line mode off");

  AST_DAC_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_WR && hit(REG_ADDR, asc_pkg::OFS_POWER_DOWN_SETUP) && REG_WDATA[4] && !wr_soft)
      |=> ##1 CLAMP_DAC_PWRDN && !CLAMP_DAC_OE)
    else $error("clamp DAC not floated on power down");

  AST_RSVD_ZERO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    REG_RD |=> !(hit($past(REG_ADDR), asc_pkg::OFS_LINE_MODE_SETUP) &&
      (REG_RDATA & ~asc_pkg::MASK_LINE_MODE_SETUP) != 8'h00) &&
      !(hit($past(REG_ADDR), asc_pkg::OFS_POWER_DOWN_SETUP) &&
      (REG_RDATA & ~asc_pkg::MASK_POWER_DOWN_SETUP) != 8'h00))
    else $error("reserved bits read non-zero");

endmodule
`default_nettype wire

// ==== design/asc_pkg.sv ====
// Constants for the front-end setup control registers.
// Assumes a serial decoder elsewhere presents whole-byte register accesses.
package asc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register locations
  localparam logic [5:0] OFS_CLAMP_AND_SAMPLE_SETUP = 6'h03;
  localparam logic [5:0] OFS_LINE_MODE_SETUP = 6'h04;
  localparam logic [5:0] OFS_POWER_DOWN_SETUP = 6'h05;
  localparam logic [5:0] OFS_COLOUR_CYCLE_RESET = 6'h0E;
  localparam logic [5:0] OFS_GLOBAL_SOFT_RESET = 6'h0F;

  // Reset values
  localparam logic [7:0] RST_CLAMP_AND_SAMPLE_SETUP = 8'h1F;
  localparam logic [7:0] RST_LINE_MODE_SETUP = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN_SETUP = 8'h00;

  // Implemented bits; the rest are reserved and read as zero
  localparam logic [7:0] MASK_CLAMP_AND_SAMPLE_SETUP = 8'hFF;
  localparam logic [7:0] MASK_LINE_MODE_SETUP = 8'h0F;
  localparam logic [7:0] MASK_POWER_DOWN_SETUP = 8'h7F;

  // Field positions, clamp_and_sample_setup
  localparam int CLAMP_LEVEL_CODE_LSB = 0;
  localparam int REF_SAMPLE_ADJUST_LSB = 4;
  localparam int MONO_CHANNEL_SEL_LSB = 6;
  // Field positions, line_mode_setup
  localparam int LINE_SEQUENTIAL_EN_BIT = 0;
  localparam int COLOUR_AUTOCYCLE_EN_BIT = 1;
  localparam int GAIN_OFFSET_MUX_SEL_LSB = 2;
  // Field positions, power_down_setup
  localparam int RED_CHAN_PWRDN_BIT = 0;
  localparam int GREEN_CHAN_PWRDN_BIT = 1;
  localparam int BLUE_CHAN_PWRDN_BIT = 2;
  localparam int CONVERTER_PWRDN_BIT = 3;
  localparam int CLAMP_DAC_PWRDN_BIT = 4;
  localparam int REF_BUFFER_PWRDN_BIT = 5;
  localparam int COMMON_LEVEL_BUF_PWRDN_BIT = 6;

  // Colour codes shared by channel select and gain/offset select
  localparam logic [1:0] COLOUR_RED = 2'h0;
  localparam logic [1:0] COLOUR_GREEN = 2'h1;
  localparam logic [1:0] COLOUR_BLUE = 2'h2;

  // Reference sample position when the adjust field is ignored
  localparam logic [1:0] REF_ADJUST_DEFAULT = 2'h1;
  localparam logic [3:0] CLAMP_LEVEL_RST = 4'hF;

endpackage

// ==== design/asc_colour_cycler.sv ====
// Colour auto-cycle counter: steps red, green, blue on each reference pin pulse.
// Assumes the reference pin is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module asc_colour_cycler (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic advance_en,
  input wire logic ref_pin,
  output logic [1:0] colour
);

  typedef enum logic [1:0] {ST_RED, ST_GREEN, ST_BLUE} asc_cycle_state_t;

  asc_cycle_state_t state_ff;
  asc_cycle_state_t nxt_state;
  logic pin_prev_ff;
  logic nxt_pin_prev;
  logic rise;

  assign rise = ref_pin & ~pin_prev_ff;

  always_comb begin
    nxt_pin_prev = ref_pin;
    nxt_state = state_ff;
    if (clear) begin
      // Clear beats a coincident pulse so the cycle restarts cleanly
      nxt_state = ST_RED;
    end else if (advance_en && rise) begin
      case (state_ff)
        ST_RED: nxt_state = ST_GREEN;
        ST_GREEN: nxt_state = ST_BLUE;
        ST_BLUE: nxt_state = ST_RED;
        default: nxt_state = ST_RED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_RED;
      pin_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pin_prev_ff <= nxt_pin_prev;
    end
  end

  always_comb begin
    case (state_ff)
      ST_RED: colour = asc_pkg::COLOUR_RED;
      ST_GREEN: colour = asc_pkg::COLOUR_GREEN;
      ST_BLUE: colour = asc_pkg::COLOUR_BLUE;
      default: colour = asc_pkg::COLOUR_RED;
    endcase
  end

  AST_CYCLE_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    clear |=> colour == asc_pkg::COLOUR_RED)
    else $error("cycle counter not returned to red");

  AST_CYCLE_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    (advance_en && rise && !clear && colour == asc_pkg::COLOUR_BLUE) |=> colour == asc_pkg::COLOUR_RED)
    else $error("cycle counter did not wrap from blue to red");

  AST_CYCLE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (!advance_en && !clear) |=> $stable(colour))
    else $error("cycle counter moved while auto-cycle inactive");

endmodule
`default_nettype wire

// ==== verification/asc_host_model.sv ====
// Host controller model: byte writes, byte reads and reference pin pulses.
// Assumes the bench calls its tasks from one process and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [5:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic ref_pin
);
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ref_pin = 1'b0;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask

  // Auto-cycle needs double sampling off elsewhere; clamp goes by its control bit
  task automatic pulse_ref;
    @(posedge clk);
    ref_pin <= 1'b1;
    @(posedge clk);
    ref_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verification/afe_setup_control_regs_tb.sv ====
// Self-checking bench for the setup control registers.
// Assumes the host model drives the register strobes and reference pin.
`timescale 1ns/1ps
`default_nettype none
module afe_setup_control_regs_tb;
  logic sys_clk;
  logic arst_n;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sync_mode;
  logic single_mode;
  logic ref_pin;
  logic [3:0] clamp_code;
  logic dac_oe;
  logic [1:0] ref_adj;
  logic [1:0] mono_sel;
  logic [1:0] gain_sel;
  logic ref_for_sampling;
  logic colour_autocycle_en_active;
  wire [6:0] pwr;
  logic soft_pulse;
  logic cyc_pulse;
  int fails = 0;
  int comparisons = 0;
  int soft_n = 0;
  int cyc_n = 0;
  logic [7:0] cr;
  logic [7:0] lr;
  logic [7:0] pr;
  logic [7:0] rb;
  logic [1:0] col;

  asc_setup_regs dut_u (.SYS_CLK(sys_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SYNC_TIMING_MODE(sync_mode),
    .SINGLE_CHANNEL_MODE(single_mode), .REF_SAMPLE_CLK_PIN(ref_pin), .CLAMP_LEVEL_CODE(clamp_code),
    .CLAMP_DAC_OE(dac_oe), .REF_SAMPLE_ADJUST(ref_adj), .MONO_CHANNEL_SEL(mono_sel),
    .GAIN_OFFSET_SEL(gain_sel), .REF_PIN_FOR_SAMPLING(ref_for_sampling), .AUTOCYCLE_ACTIVE(colour_autocycle_en_active),
    .RED_CHAN_PWRDN(pwr[0]), .GREEN_CHAN_PWRDN(pwr[1]), .BLUE_CHAN_PWRDN(pwr[2]),
    .CONVERTER_PWRDN(pwr[3]), .CLAMP_DAC_PWRDN(pwr[4]), .REF_BUFFER_PWRDN(pwr[5]),
    .COMMON_LEVEL_BUF_PWRDN(pwr[6]), .SOFT_RESET_PULSE(soft_pulse), .CYCLE_RESET_PULSE(cyc_pulse));

  asc_host_model host_u (.clk(sys_clk), .rdata(reg_rdata), .addr(reg_addr), .wdata(reg_wdata),
    .wr(reg_wr), .rd(reg_rd), .ref_pin(ref_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    soft_n <= soft_n + int'(soft_pulse);
    cyc_n <= cyc_n + int'(cyc_pulse);
  end

  function automatic logic [1:0] exp_gain(input logic [7:0] l, input logic [1:0] c);
    if (!l[0]) begin
      return 2'h0;
    end
    return l[1] ? c : l[3:2];
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_outs;
    chk("clamp code", {4'h0, cr[3:0]}, {4'h0, clamp_code});
    chk("ref adjust", {6'h0, sync_mode ? cr[5:4] : 2'h1}, {6'h0, ref_adj});
    chk("mono select", {6'h0, single_mode ? cr[7:6] : 2'h0}, {6'h0, mono_sel});
    chk("gain select", {6'h0, exp_gain(lr, col)}, {6'h0, gain_sel});
    chk("autocycle", {7'h0, lr[0] & lr[1]}, {7'h0, colour_autocycle_en_active});
    chk("ref for sampling", {7'h0, ~(lr[0] & lr[1])}, {7'h0, ref_for_sampling});
    chk("power bits", {1'b0, pr[6:0]}, {1'b0, pwr});
    chk("dac drive", {7'h0, ~pr[4]}, {7'h0, dac_oe});
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    host_u.rd_byte(a, rb);
    chk("readback", exp, rb);
  endtask

  // One write to a strobe location must give exactly one pulse
  task automatic strobe(input logic [5:0] a);
    int s0;
    int c0;
    s0 = soft_n;
    c0 = cyc_n;
    host_u.wr_byte(a, 8'($urandom));
    repeat (4) @(posedge sys_clk);
    chk("soft pulses", (a == 6'h0F) ? 8'h01 : 8'h00, 8'(soft_n - s0));
    chk("cycle pulses", (a == 6'h0E) ? 8'h01 : 8'h00, 8'(cyc_n - c0));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fails++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    sync_mode = 1'b0;
    single_mode = 1'b0;
    cr = 8'h1F;
    lr = 8'h00;
    pr = 8'h00;
    col = 2'h0;
    void'($urandom(32));
    repeat (10) @(posedge sys_clk);
    chk_outs();
    arst_n <= 1'b1;
    strobe(6'h0F);
    rd_chk(6'h03, 8'h1F);
    rd_chk(6'h04, 8'h00);
    rd_chk(6'h05, 8'h00);
    for (int i = 0; i < 24; i++) begin
      cr = (i < 4) ? 8'(8'h3C << (2 * i)) : 8'($urandom);
      sync_mode <= 1'($urandom);
      single_mode <= 1'($urandom);
      host_u.wr_byte(6'h03, cr);
      repeat (3) @(posedge sys_clk);
      chk_outs();
      rd_chk(6'h03, cr);
    end
    for (int i = 0; i < 24; i++) begin
      lr = (i == 0) ? 8'hFF : 8'($urandom) & 8'h0F;
      pr = (i == 1) ? 8'hFF : 8'($urandom) & 8'h7F;
      strobe(6'h0E);
      col = 2'h0;
      host_u.wr_byte(6'h04, lr);
      host_u.wr_byte(6'h05, pr);
      lr = lr & 8'h0F;
      pr = pr & 8'h7F;
      repeat (3) @(posedge sys_clk);
      chk_outs();
      rd_chk(6'h04, lr);
      rd_chk(6'h05, pr);
    end
    lr = 8'h02;
    host_u.wr_byte(6'h04, lr);
    host_u.pulse_ref();
    chk_outs();
    lr = 8'h03;
    host_u.wr_byte(6'h04, lr);
    for (int k = 0; k < 5; k++) begin
      host_u.pulse_ref();
      col = (col == 2'h2) ? 2'h0 : col + 2'h1;
      chk_outs();
    end
    // Counter stands on blue here, so the clear has something to undo
    strobe(6'h0E);
    col = 2'h0;
    chk_outs();
    host_u.pulse_ref();
    col = 2'h1;
    pr = 8'h55;
    host_u.wr_byte(6'h05, pr);
    repeat (3) @(posedge sys_clk);
    chk_outs();
    strobe(6'h0F);
    cr = 8'h1F;
    lr = 8'h00;
    pr = 8'h00;
    col = 2'h0;
    chk_outs();
    rd_chk(6'h03, 8'h1F);
    rd_chk(6'h05, 8'h00);
    lr = 8'h03;
    host_u.wr_byte(6'h04, lr);
    repeat (3) @(posedge sys_clk);
    chk_outs();
    strobe(6'h3F);
    rd_chk(6'h3F, 8'h00);
    rd_chk(6'h0F, 8'h00);
    rd_chk(6'h0E, 8'h00);
    chk_outs();
    pr = 8'h7F;
    host_u.wr_byte(6'h05, pr);
    repeat (3) @(posedge sys_clk);
    chk_outs();
    // Hardware reset in mid-run must bring back every reset value
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    lr = 8'h00;
    pr = 8'h00;
    col = 2'h0;
    repeat (2) @(posedge sys_clk);
    chk_outs();
    rd_chk(6'h04, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
